// [hw/bbx_exec.sv]
/*
  bbx_exec: executes the relative jump, jump-if-nonzero and set-single-bit
  operations over a four-phase instruction cycle. Assumes the fetch unit
  holds instr_in stable from Q1 to Q4, that the data memory answers a read
  address combinationally within the same phase, and that the core
  supplies the zero flag, bank select and index register levels.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - relative jump: 11010 plus 11-bit signed offset
// - jump target is pc plus two plus 2n
// - relative jump: two cycles, second flushes prefetch
// - zero set: continue at pc plus two
// - set bit: force one bit, others unchanged
// - bank flag picks access bank or bank select
// - extended set, flag clear, addr<=95: indexed offset
// - nonzero jump: 11100001, 8-bit offset, zero clear
module bbx_exec (
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  // instruction and core state
  input  wire logic [15:0]               instr_in,
  input  wire logic                      zero_flag_in,
  input  wire logic [3:0]                bank_select_register_in,
  input  wire logic                      ext_set_en_in,
  input  wire logic [bbx_pkg::DADDR_W-1:0] index_base_in,
  // data memory read
  input  wire logic [7:0]                dmem_rdata_in,
  output logic [bbx_pkg::DADDR_W-1:0]    dmem_raddr_out,
  // data memory write
  output var bbx_pkg::bbx_dmem_wr_s      dmem_wr_out,
  // program flow
  output logic [bbx_pkg::PC_W-1:0]       pc_out,
  output logic                           flush_out,
  output logic [3:0]                     phase_out
);

  bbx_pkg::bbx_dec_s dec;

  bbx_decode u_decode (
    .instr_in (instr_in),
    .dec_out  (dec)
  );

  bbx_pkg::bbx_phase_e phase_ff, nxt_phase;
  logic [bbx_pkg::PC_W-1:0]    pc_ff;
  logic                        flush_ff;
  logic                        flush_cyc_ff;
  logic [7:0]                  rdata_ff;
  logic [7:0]                  mod_ff;
  logic [bbx_pkg::DADDR_W-1:0] addr_ff;
  logic [bbx_pkg::DADDR_W-1:0] raddr_ff;
  bbx_pkg::bbx_dmem_wr_s       wr_ff;

  always_comb begin
    case (phase_ff)
      bbx_pkg::Q1: nxt_phase = bbx_pkg::Q2;
      bbx_pkg::Q2: nxt_phase = bbx_pkg::Q3;
      bbx_pkg::Q3: nxt_phase = bbx_pkg::Q4;
      bbx_pkg::Q4: nxt_phase = bbx_pkg::Q1;
      default:     nxt_phase = bbx_pkg::Q1;
    endcase
  end

  // an instruction during a flush cycle is the discarded prefetch
  wire logic live = !flush_cyc_ff;

  // effective data address; the indexed sum wraps inside the 12-bit data
  // space, so an index near the top reaches bank 0 without any warning
  wire logic use_ilo   = !dec.bank_flag && ext_set_en_in
                         && (dec.faddr <= bbx_pkg::ILO_LIMIT);
  wire logic acc_low   = dec.faddr <= bbx_pkg::ACC_LOW_LIMIT;
  wire logic [bbx_pkg::DADDR_W-1:0] ilo_addr =
    index_base_in + {4'h0, dec.faddr};
  wire logic [bbx_pkg::DADDR_W-1:0] acc_addr =
    acc_low ? {4'h0, dec.faddr} : {bbx_pkg::ACC_HIGH_BANK, dec.faddr};
  wire logic [bbx_pkg::DADDR_W-1:0] bank_addr =
    {bank_select_register_in, dec.faddr};
  wire logic [bbx_pkg::DADDR_W-1:0] eff_addr =
    dec.bank_flag ? bank_addr : (use_ilo ? ilo_addr : acc_addr);

  // program counter update
  wire logic [bbx_pkg::PC_W-1:0] pc_inc = pc_ff + bbx_pkg::PC_STEP;
  wire logic [bbx_pkg::PC_W-1:0] pc_tgt = pc_inc + dec.ofs2;
  wire logic take_jump = live && (dec.is_rjmp || (dec.is_jnz && !zero_flag_in));
  // not taken (zero set) falls through to the plain increment
  wire logic [bbx_pkg::PC_W-1:0] pc_commit = take_jump ? pc_tgt : pc_inc;

  // only the addressed bit is forced; no status flag is touched here
  wire logic [7:0] set_mask = 8'h01 << dec.bit_idx;
  wire logic [7:0] set_data = rdata_ff | set_mask;
  wire logic       do_setb  = live && dec.is_setb;

  // quarter strobes
  wire logic at_q1;
  wire logic at_q2;
  wire logic at_q3;
  wire logic at_q4;
  assign at_q1 = (phase_ff == bbx_pkg::Q1);
  assign at_q2 = (phase_ff == bbx_pkg::Q2);
  assign at_q3 = (phase_ff == bbx_pkg::Q3);
  assign at_q4 = (phase_ff == bbx_pkg::Q4);

  // next values: a register loads only in its own quarter, so a word that
  // changes after Q1 cannot move the address of a read-modify-write under way,
  // but its bit index is still taken at Q3 and its opcode gates the write at Q4
  wire logic [bbx_pkg::DADDR_W-1:0] nxt_raddr;
  wire logic [bbx_pkg::DADDR_W-1:0] nxt_addr;
  wire logic [7:0]                  nxt_rdata;
  wire logic [7:0]                  nxt_mod;
  wire logic [bbx_pkg::PC_W-1:0]    nxt_pc;
  wire logic                        nxt_flush;
  wire logic                        nxt_flush_cyc;
  wire bbx_pkg::bbx_dmem_wr_s       nxt_wr;
  assign nxt_raddr     = at_q1 ? eff_addr : raddr_ff;
  assign nxt_addr      = at_q1 ? eff_addr : addr_ff;
  assign nxt_rdata     = at_q2 ? dmem_rdata_in : rdata_ff;
  assign nxt_mod       = at_q3 ? set_data : mod_ff;
  assign nxt_pc        = at_q4 ? pc_commit : pc_ff;
  assign nxt_flush     = at_q4 ? take_jump : flush_ff;
  assign nxt_flush_cyc = at_q4 ? take_jump : flush_cyc_ff;
  // the write strobe is a one-clock pulse in the slot after Q4; address and
  // data hold afterwards so a slow memory may still sample them
  assign nxt_wr.wr     = at_q4 && do_setb;
  assign nxt_wr.addr   = at_q4 ? addr_ff : wr_ff.addr;
  assign nxt_wr.data   = at_q4 ? mod_ff : wr_ff.data;

  // the quarter counter runs free; only reset realigns it with the fetch
  // unit, which must start its first word in the clock after release
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      phase_ff <= bbx_pkg::Q1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // program flow
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pc_ff <= bbx_pkg::PC_RST;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // a taken jump blanks exactly the next instruction cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flush_ff <= 1'b0;
    end else begin
      flush_ff <= nxt_flush;
    end
  end

  // flush_cyc_ff mirrors flush_ff so the execution gate never loads the
  // output; synthesis may merge the two
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flush_cyc_ff <= 1'b0;
    end else begin
      flush_cyc_ff <= nxt_flush_cyc;
    end
  end

  // read-modify-write path
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      raddr_ff <= '0;
    end else begin
      raddr_ff <= nxt_raddr;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      addr_ff <= '0;
    end else begin
      addr_ff <= nxt_addr;
    end
  end

  // read data is taken at the Q2 edge only: the memory has one clock to answer
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mod_ff <= 8'h00;
    end else begin
      mod_ff <= nxt_mod;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
    end
  end

  assign dmem_raddr_out = raddr_ff;
  assign dmem_wr_out    = wr_ff;
  assign pc_out         = pc_ff;
  assign flush_out      = flush_ff;
  assign phase_out      = phase_ff;

endmodule : bbx_exec
`default_nettype wire

// [hw/bbx_pkg.sv]
/*
  bbx_pkg: shared constants and carrier structs for the branch and bit-set
  execution block. Assumes a 16-bit instruction word and a byte-addressed
  program counter of 21 bits.
*/
`default_nettype none
package bbx_pkg;

  localparam int PC_W = 21;

  // opcode field layout
  localparam logic [4:0] RJMP_OPC       = 5'h1a;   // 1101 0
  localparam int         RJMP_OPC_LSB   = 11;
  localparam int         RJMP_OFS_W     = 11;
  localparam logic [7:0] JNZ_OPC        = 8'he1;   // 1110 0001
  localparam int         JNZ_OPC_LSB    = 8;
  localparam int         JNZ_OFS_W      = 8;
  localparam logic [3:0] SETB_OPC       = 4'h8;    // 1000
  localparam int         SETB_OPC_LSB   = 12;
  localparam int         SETB_BIT_LSB   = 9;
  localparam int         SETB_BANK_POS  = 8;

  // addressing
  localparam logic [7:0] ILO_LIMIT      = 8'h5f;   // indexed literal offset at or below
  localparam logic [7:0] ACC_LOW_LIMIT  = 8'h5f;   // access bank low half ends here
  localparam logic [3:0] ACC_HIGH_BANK  = 4'hf;    // access bank upper half maps here
  localparam int         DADDR_W        = 12;

  // step sizes and reset values
  localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;
  localparam logic [PC_W-1:0] PC_RST    = 21'h000000;
  localparam logic [3:0]      BANK_RST  = 4'h0;

  typedef enum logic [3:0] {
    Q1 = 4'b0001,
    Q2 = 4'b0010,
    Q3 = 4'b0100,
    Q4 = 4'b1000
  } bbx_phase_e;

  typedef struct packed {
    logic                wr;
    logic [DADDR_W-1:0]  addr;
    logic [7:0]          data;
  } bbx_dmem_wr_s;

  typedef struct packed {
    logic                is_rjmp;
    logic                is_jnz;
    logic                is_setb;
    logic [PC_W-1:0]     ofs2;      // sign-extended offset times two
    logic [2:0]          bit_idx;
    logic                bank_flag;
    logic [7:0]          faddr;
  } bbx_dec_s;

endpackage : bbx_pkg
`default_nettype wire

// [hw/bbx_decode.sv]
/*
  bbx_decode: pure combinational decode of one instruction word into the
  carrier struct. Assumes the word is stable for the whole instruction cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module bbx_decode (
  // instruction in
  input  wire logic [15:0]       instr_in,
  // decoded fields out
  output var  bbx_pkg::bbx_dec_s dec_out
);

  function automatic logic [bbx_pkg::PC_W-1:0] sext2(input logic [10:0] v, input int w);
    logic [bbx_pkg::PC_W-1:0] r;
    r = '0;
    for (int i = 0; i < bbx_pkg::PC_W; i++) begin
      r[i] = (i == 0) ? 1'b0 : ((i - 1 < w) ? v[i - 1] : v[w - 1]);
    end
    return r;
  endfunction : sext2

  wire logic is_rjmp = (instr_in[15:bbx_pkg::RJMP_OPC_LSB] == bbx_pkg::RJMP_OPC);
  wire logic is_jnz  = (instr_in[15:bbx_pkg::JNZ_OPC_LSB] == bbx_pkg::JNZ_OPC);
  wire logic is_setb = (instr_in[15:bbx_pkg::SETB_OPC_LSB] == bbx_pkg::SETB_OPC);

  wire logic [bbx_pkg::PC_W-1:0] ofs_long  = sext2(instr_in[10:0], bbx_pkg::RJMP_OFS_W);
  wire logic [bbx_pkg::PC_W-1:0] ofs_short = sext2({3'h0, instr_in[7:0]}, bbx_pkg::JNZ_OFS_W);

  assign dec_out.is_rjmp   = is_rjmp;
  assign dec_out.is_jnz    = is_jnz;
  assign dec_out.is_setb   = is_setb;
  assign dec_out.ofs2      = is_rjmp ? ofs_long : ofs_short;
  assign dec_out.bit_idx   = instr_in[11:bbx_pkg::SETB_BIT_LSB];
  assign dec_out.bank_flag = instr_in[bbx_pkg::SETB_BANK_POS];
  assign dec_out.faddr     = instr_in[7:0];

endmodule : bbx_decode
`default_nettype wire

// [test/bbx_exec_properties.sv]
/* bbx_exec_properties: port checks for bbx_exec.
   Assumes inputs stay steady over each instruction cycle. */
`timescale 1ns/1ps
`default_nettype none
module bbx_exec_properties (
  input wire logic                  clk_in,
  input wire logic                  rst_n_in,
  input wire logic [15:0]           instr_in,
  input wire logic                  zero_flag_in,
  input wire logic [3:0]            bank_select_register_in,
  input wire logic                  ext_set_en_in,
  input wire logic [11:0]           index_base_in,
  input wire logic [7:0]            dmem_rdata_in,
  input wire logic [11:0]           dmem_raddr_out,
  input wire bbx_pkg::bbx_dmem_wr_s dmem_wr_out,
  input wire logic [20:0]           pc_out,
  input wire logic                  flush_out,
  input wire logic [3:0]            phase_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire [7:0] fa = instr_in[7:0];
  wire lo = fa <= 8'h5f;
  wire [11:0] ea = instr_in[8] ? {bank_select_register_in, fa}
    : (ext_set_en_in && lo) ? index_base_in + {4'h0, fa} : {lo ? 4'h0 : 4'hf, fa};
  wire [20:0] rj = {{9{instr_in[10]}}, instr_in[10:0], 1'b0};
  wire [20:0] nz = {{12{instr_in[7]}}, instr_in[7:0], 1'b0};
  wire q1 = phase_out == 4'b0001;
  wire q4 = phase_out == 4'b1000;
  wire setb = instr_in[15:12] == 4'h8 && !flush_out;
  a_phase_rotate: assert property (!q4 |=> phase_out == $past(phase_out) << 1)
    else $error("phase did not advance");
  a_pc_hold: assert property (!q1 |-> $stable(pc_out))
    else $error("pc moved outside Q4 commit");
  a_rjmp_target: assert property (q4 && !flush_out && instr_in[15:11] == 5'h1a
    |=> pc_out == $past(pc_out) + 21'h2 + $past(rj) && flush_out) else $error("bad jump target");
  a_jnz_target: assert property (q4 && !flush_out && instr_in[15:8] == 8'he1 |=>
    pc_out == $past(pc_out) + 21'h2 + ($past(zero_flag_in) ? 21'h0 : $past(nz))
    && flush_out == !$past(zero_flag_in)) else $error("bad nonzero jump");
  a_jnz_fall: assert property (q4 && !flush_out && zero_flag_in
    && instr_in[15:8] == 8'he1 |=> pc_out == $past(pc_out) + 21'h2 && !flush_out)
    else $error("zero set but jump taken");
  a_flush_len: assert property ($rose(flush_out) |-> q1 ##0 flush_out[*4] ##1 !flush_out)
    else $error("flush length wrong");
  a_flush_skip: assert property (q4 && flush_out |=>
    pc_out == $past(pc_out) + 21'h2 && !dmem_wr_out.wr) else $error("flushed word executed");
  a_setb_addr: assert property (phase_out == 4'b0010 && setb |-> dmem_raddr_out == ea)
    else $error("bad bit-set address");
  a_wr_slot: assert property (dmem_wr_out.wr |-> q1 && dmem_wr_out.addr == $past(dmem_raddr_out, 3))
    else $error("write slot or address wrong");
  a_setb_data: assert property (dmem_wr_out.wr |-> dmem_wr_out.data ==
    ($past(dmem_rdata_in, 3) | (8'h01 << $past(instr_in[11:9])))) else $error("bad set data");
  a_setb_write: assert property (q4 && setb |=> dmem_wr_out.wr)
    else $error("bit-set not written");
endmodule : bbx_exec_properties
bind bbx_exec bbx_exec_properties u_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .instr_in(instr_in), .zero_flag_in(zero_flag_in), .ext_set_en_in(ext_set_en_in),
  .bank_select_register_in(bank_select_register_in), .index_base_in(index_base_in),
  .dmem_rdata_in(dmem_rdata_in), .dmem_raddr_out(dmem_raddr_out), .pc_out(pc_out),
  .dmem_wr_out(dmem_wr_out), .flush_out(flush_out), .phase_out(phase_out));
`default_nettype wire

// [test/bbx_exec_bench.sv]
/* bbx_exec_bench: directed boundary words, then random words, for bbx_exec.
   Assumes the first cycle after reset is Q1 and runs a cleared word. */
`timescale 1ns/1ps
`default_nettype none
module bbx_exec_bench;
  logic                  clk_in = 1'b0;
  logic                  rst_n_in = 1'b0;
  logic [15:0]           instr = 16'h0000;
  logic                  zf = 1'b0;
  logic [3:0]            bank_sel = 4'h0;
  logic                  ext_en = 1'b0;
  logic [11:0]           idx = 12'h000;
  logic [7:0]            rdata = 8'h00;
  logic [11:0]           raddr;
  bbx_pkg::bbx_dmem_wr_s wr;
  logic [20:0]           pc;
  logic                  flush;
  logic [3:0]            phase;
  logic [42:0]           notes[$];
  logic [42:0]           e;
  logic [20:0]           exp_pc = 21'h000002;
  logic                  pend = 1'b0;
  int                    n_errors = 0;
  int                    checked = 0;
  int                    seed = 13;
  logic [31:0]           r;
  // a cleared word follows each jump so the boundary word after it is not the dropped one
  logic [15:0] dir [0:12] = '{16'hd400, 16'h0000, 16'hd3ff, 16'h0000, 16'hd001,
                              16'h0000, 16'he180, 16'h0000, 16'he17f, 16'h0000,
                              16'h8e5f, 16'h8060, 16'h8f05};
  always #4 clk_in = ~clk_in;
  bbx_exec dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_in(instr), .zero_flag_in(zf),
    .bank_select_register_in(bank_sel), .ext_set_en_in(ext_en), .index_base_in(idx),
    .dmem_rdata_in(rdata), .dmem_raddr_out(raddr), .dmem_wr_out(wr), .pc_out(pc),
    .flush_out(flush), .phase_out(phase));
  task automatic final_report;
    $display("checked %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [20:0] x, input logic [20:0] g);
    checked++;
    if (x !== g) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, x, g);
    end
  endtask : chk
  task automatic step(input logic [15:0] w);
    logic [42:0] n;
    logic        tk;
    int          i;
    n = '0;
    i = 0;
    do begin @(negedge clk_in); i++; end while (phase !== 4'b0001 && i < 8);
    if (phase !== 4'b0001) begin n_errors++; final_report(); end
    r = $random(seed);
    instr = w;
    {rdata, idx, ext_en, bank_sel, zf} = r[25:0];
    // a word fetched behind a taken jump is dropped but pc still steps
    tk = !pend && (w[15:11] == 5'h1a || (w[15:8] == 8'he1 && !zf));
    n[42] = tk;
    n[41:21] = exp_pc + 21'h2 + (!tk ? 21'h0 : w[13] ? {{12{w[7]}}, w[7:0], 1'b0}
                                                  : {{9{w[10]}}, w[10:0], 1'b0});
    if (!pend && w[15:12] == 4'h8) begin
      n[20] = 1'b1;
      n[19:8] = w[8] ? {bank_sel, w[7:0]} : (ext_en && w[7:0] <= 8'h5f) ?
        idx + {4'h0, w[7:0]} : {(w[7:0] <= 8'h5f) ? 4'h0 : 4'hf, w[7:0]};
      n[7:0] = rdata | (8'h01 << w[11:9]);
    end
    pend = tk;
    exp_pc = n[41:21];
    #1 notes.push_back(n);
  endtask : step
  initial forever begin
    @(negedge clk_in);
    if (phase === 4'b0001 && notes.size() > 0) begin
      e = notes.pop_front();
      chk("pc", e[41:21], pc);
      chk("write strobe", {20'h0, e[20]}, {20'h0, wr.wr});
      chk("flush", {20'h0, e[42]}, {20'h0, flush});
      if (e[20]) chk("write addr", {9'h0, e[19:8]}, {9'h0, wr.addr});
      if (e[20]) chk("write data", {13'h0, e[7:0]}, {13'h0, wr.data});
    end
  end
  initial begin
    repeat (4) @(negedge clk_in);
    rst_n_in = 1'b1;
    foreach (dir[k]) step(dir[k]);
    $display("test directed done");
    repeat (400) begin
      r = $random(seed);
      step(r[17:16] == 2'h0 ? {5'h1a, r[10:0]} : r[17:16] == 2'h1 ? {8'he1, r[7:0]} :
           r[17:16] == 2'h2 ? {4'h8, r[11:0]} : r[15:0]);
    end
    $display("test random done");
    step(16'h0000);
    final_report();
  end
endmodule : bbx_exec_bench
`default_nettype wire
